// File: common/crcs_pkg.sv
// Package: register map, field positions and reset values of the CRC engine
package crcs_pkg;
  // Register byte offsets on APB
  localparam logic [7:0] OFS_CONTROL_0 = 8'h00;
  localparam logic [7:0] OFS_CONTROL_1 = 8'h04;
  localparam logic [7:0] OFS_DATA_HIGH = 8'h08;
  localparam logic [7:0] OFS_DATA_LOW = 8'h0C;
  localparam logic [7:0] OFS_SCAN_CTRL = 8'h10;
  localparam logic [7:0] OFS_ACCUM = 8'h14;
  localparam logic [7:0] OFS_POLY = 8'h18;
  // Control 0 fields
  localparam int BIT_ENABLE = 7;
  localparam int BIT_START = 6;
  localparam int BIT_BUSY = 5;
  localparam int BIT_AUGMENT = 4;
  localparam int BIT_DIRECTION = 1;
  localparam int BIT_FULL = 0;
  // Control 1 fields
  localparam int POS_WORD_LEN = 4;
  localparam int POS_POLY_LEN = 0;
  // Scanner control fields
  localparam int BIT_SCAN_ENABLE = 7;
  localparam int BIT_SCAN_GO = 6;
  localparam int BIT_SCAN_BUSY = 5;
  localparam int POS_SCAN_MODE = 0;
  // Scanner mode encodings
  localparam logic [1:0] MODE_CONCURRENT = 2'h0;
  localparam logic [1:0] MODE_BURST = 2'h1;
  localparam logic [1:0] MODE_PEEK = 2'h2;
  localparam logic [1:0] MODE_TRIGGERED = 2'h3;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
endpackage : crcs_pkg

// File: verilog/crcs_engine.sv
// CRC engine with program memory scanner and debug freeze hooks
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps

// Contract
// - Watchdog untouched by scanner activity
// - Debug halt freezes scanner until resume
// - Halt at go-set cycle defers burst
// - Halt lets running memory access finish
// - Halted burst resumes where it stopped
// - Halt before scan defers scan, instruction
// - PC breakpoint: due scan completes first
// - Data breakpoint: requested scan waits
// - Single step: pending scan reads first
// - Software breakpoint: scan access goes first
// - Peek slot of skipped instruction deferred
// - Enable bit seven releases engine reset
// - Start bit six runs shifter
// - Busy bit five while shifting pending
// - Bit four selects zero augmentation
// - Bit one selects shift direction
// - Full bit zero while word unconsumed
// - Control 1 bits 7-4 word length
// - Control 1 bits 3-0 poly length
// - Low byte write loads whole word
// - Scanner waits for engine ready
// - Mode field selects scanner mode
// - Burst stalls processor until end
module crcs_engine (
  input wire logic clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Debug and core handshake
  input wire logic debug_halt,
  input wire logic cpu_dead_cycle,
  input wire logic scan_trigger,
  input wire logic scan_end,
  output logic mem_read,
  output logic cpu_stall,
  input wire logic [15:0] mem_data
);

  //////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic wr_en;
  logic rd_en;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign pready = 1'b1;  // Zero wait states
  assign pslverr = 1'b0;

  // Stored registers
  logic [7:0] ctrl0_ff;
  logic [7:0] ctrl1_ff;
  logic [7:0] data_high_ff;
  logic [7:0] data_low_ff;
  logic [7:0] scan_ctrl_ff;
  logic [15:0] accum_ff;
  logic [15:0] poly_ff;
  // Engine state
  logic [15:0] shift_ff;
  logic [4:0] bits_left_ff;
  logic [4:0] aug_left_ff;
  logic full_ff;
  logic scan_go_ff;
  logic scan_access_ff;
  logic sync_trig_a_ff;
  logic sync_trig_b_ff;
  logic sync_trig_c_ff;
  logic trig_level_ff;  // Filtered trigger level

  logic enable;
  logic running;
  logic busy;
  logic engine_ready;
  logic load_word;
  logic scan_fetch;
  assign enable = ctrl0_ff[crcs_pkg::BIT_ENABLE];
  assign running = enable & ctrl0_ff[crcs_pkg::BIT_START];
  assign busy = full_ff | (bits_left_ff != 5'h00) |
                (aug_left_ff != 5'h00);
  assign engine_ready = running & ~full_ff;

  //////////////////////////////////////////////////////////////////////////
  // Register writes; status bits are computed, not stored
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl0_ff <= crcs_pkg::RST_BYTE;
      ctrl1_ff <= crcs_pkg::RST_BYTE;
      data_high_ff <= crcs_pkg::RST_BYTE;
      data_low_ff <= crcs_pkg::RST_BYTE;
      scan_ctrl_ff <= crcs_pkg::RST_BYTE;
      poly_ff <= crcs_pkg::RST_WORD;
    end else if (wr_en) begin
      unique case (paddr)
        crcs_pkg::OFS_CONTROL_0: begin
          ctrl0_ff <= pwdata[7:0] & 8'hD2;
        end
        crcs_pkg::OFS_CONTROL_1: begin
          ctrl1_ff <= pwdata[7:0];
        end
        crcs_pkg::OFS_DATA_HIGH: begin
          data_high_ff <= pwdata[7:0];
        end
        crcs_pkg::OFS_DATA_LOW: begin
          data_low_ff <= pwdata[7:0];
        end
        crcs_pkg::OFS_SCAN_CTRL: begin
          scan_ctrl_ff <= pwdata[7:0] & 8'h83;
        end
        crcs_pkg::OFS_POLY: begin
          poly_ff <= pwdata[15:0];
        end
        default: begin
          // Unmapped: ignored
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Scanner: go flag, set by software, cleared by hardware end
  logic scan_on;
  logic [1:0] scan_mode;
  logic scan_slot;
  logic go_write;
  assign scan_on = scan_ctrl_ff[crcs_pkg::BIT_SCAN_ENABLE];
  assign scan_mode = scan_ctrl_ff[1:0];
  assign go_write = wr_en & (paddr == crcs_pkg::OFS_SCAN_CTRL);
  // Trigger level moves only once second and third stages agree, so a
  // single unsettled sample cannot open a scan slot
  logic trig_edge;
  assign trig_edge = trig_level_ff;
  // Mode dependent slot; halt blocks new access
  always_comb begin
    unique case (scan_mode)
      crcs_pkg::MODE_PEEK: scan_slot = cpu_dead_cycle;
      crcs_pkg::MODE_TRIGGERED: scan_slot = trig_edge;
      default: scan_slot = 1'b1;
    endcase
  end
  // Halt sampled before issue; access in flight is not affected
  assign scan_fetch = scan_on & scan_go_ff & ~scan_access_ff &
                      engine_ready & scan_slot & ~debug_halt;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_trig_a_ff <= 1'b0;
      sync_trig_b_ff <= 1'b0;
      sync_trig_c_ff <= 1'b0;
      trig_level_ff <= 1'b0;
    end else begin
      sync_trig_a_ff <= scan_trigger;
      sync_trig_b_ff <= sync_trig_a_ff;
      sync_trig_c_ff <= sync_trig_b_ff;
      if (sync_trig_b_ff == sync_trig_c_ff) begin
        trig_level_ff <= sync_trig_c_ff;
      end
    end
  end

  // Go bit: hardware end clears it; software set wins same cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scan_go_ff <= 1'b0;
    end else if (go_write) begin
      // Enable and go may come in one write; the written enable decides
      scan_go_ff <= pwdata[crcs_pkg::BIT_SCAN_ENABLE] &
                    pwdata[crcs_pkg::BIT_SCAN_GO];
    end else if (!scan_on) begin
      scan_go_ff <= 1'b0;
    end else if (scan_end && !debug_halt) begin
      scan_go_ff <= 1'b0;  // frozen while halted
    end
  end

  // One cycle memory access; completes even if halt rises
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scan_access_ff <= 1'b0;
    end else begin
      scan_access_ff <= scan_fetch;
    end
  end
  assign mem_read = scan_fetch;
  // Burst stalls the core for the whole scan; concurrent and triggered stall per access, peek never stalls
  assign cpu_stall = (scan_mode == crcs_pkg::MODE_BURST) ?
                     (scan_on & scan_go_ff) :
                     (scan_fetch & (scan_mode != crcs_pkg::MODE_PEEK));
  // No watchdog kick exists here, by intent

  //////////////////////////////////////////////////////////////////////////
  // Data path: low byte write or scanner fetch loads the input word
  logic cpu_load;
  assign cpu_load = wr_en & (paddr == crcs_pkg::OFS_DATA_LOW);
  assign load_word = cpu_load | scan_access_ff;
  logic [15:0] input_word;
  assign input_word = scan_access_ff ? mem_data :
                      {data_high_ff, pwdata[7:0]};
  logic [15:0] pending_ff;
  logic [3:0] word_length_minus_one;
  logic [3:0] poly_length_minus_one;
  assign word_length_minus_one = ctrl1_ff[7:4];
  assign poly_length_minus_one = ctrl1_ff[3:0];
  logic take;
  assign take = running & full_ff & (bits_left_ff == 5'h00) &
                (aug_left_ff == 5'h00);

  // Full flag: load set wins over consume clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      full_ff <= 1'b0;
      pending_ff <= crcs_pkg::RST_WORD;
    end else if (!enable) begin
      full_ff <= 1'b0;
    end else if (load_word) begin
      full_ff <= 1'b1;
      pending_ff <= input_word;
    end else if (take) begin
      full_ff <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Serial shifter and accumulator, one bit per clock
  logic feed_bit;
  logic fb;
  logic [15:0] poly_mask;
  logic [3:0] top;
  assign top = poly_length_minus_one;
  assign poly_mask = poly_ff | 16'h0001;
  logic [15:0] nxt_accum;
  always_comb begin
    nxt_accum = accum_ff;
    feed_bit = 1'b0;
    if (bits_left_ff != 5'h00) begin
      feed_bit = ctrl0_ff[crcs_pkg::BIT_DIRECTION] ? shift_ff[0] :
                 shift_ff[word_length_minus_one];
    end
    fb = accum_ff[top] ^ feed_bit;
    if (ctrl0_ff[crcs_pkg::BIT_AUGMENT]) begin
      fb = accum_ff[top];  // bit enters after shift
    end
    nxt_accum = {accum_ff[14:0], 1'b0};
    if (ctrl0_ff[crcs_pkg::BIT_AUGMENT]) begin
      nxt_accum[0] = feed_bit;
    end
    if (fb) begin
      nxt_accum = nxt_accum ^ (poly_mask & ~16'h0001) ^
                  {15'h0000, ~ctrl0_ff[crcs_pkg::BIT_AUGMENT]};
    end
  end

  logic step;
  assign step = running & ((bits_left_ff != 5'h00) |
                (aug_left_ff != 5'h00));

  // Shifter state: cleared on disable, registers kept
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_ff <= crcs_pkg::RST_WORD;
      bits_left_ff <= 5'h00;
      aug_left_ff <= 5'h00;
    end else if (!enable) begin
      shift_ff <= crcs_pkg::RST_WORD;
      bits_left_ff <= 5'h00;
      aug_left_ff <= 5'h00;
    end else if (take) begin
      shift_ff <= pending_ff;
      bits_left_ff <= {1'b0, word_length_minus_one} + 5'h01;
      aug_left_ff <= 5'h00;
    end else if (step) begin
      if (bits_left_ff != 5'h00) begin
        shift_ff <= ctrl0_ff[crcs_pkg::BIT_DIRECTION] ?
                    {1'b0, shift_ff[15:1]} : {shift_ff[14:0], 1'b0};
        bits_left_ff <= bits_left_ff - 5'h01;
        // Augmented mode flushes poly length zeros after the data
        if (bits_left_ff == 5'h01 && !full_ff &&
            ctrl0_ff[crcs_pkg::BIT_AUGMENT]) begin
          aug_left_ff <= {1'b0, top} + 5'h01;
        end
      end else begin
        aug_left_ff <= aug_left_ff - 5'h01;
      end
    end
  end

  // Accumulator: software write, or one step per shifted bit
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      accum_ff <= crcs_pkg::RST_WORD;
    end else if (wr_en && paddr == crcs_pkg::OFS_ACCUM) begin
      accum_ff <= pwdata[15:0];
    end else if (step) begin
      accum_ff <= nxt_accum;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read mux; data out comes from a flop
  logic [31:0] nxt_rdata;
  always_comb begin
    nxt_rdata = 32'h00000000;
    unique case (paddr)
      crcs_pkg::OFS_CONTROL_0: begin
        nxt_rdata[7:0] = {ctrl0_ff[7:6], busy, ctrl0_ff[4], 2'h0,
                          ctrl0_ff[1], full_ff};
      end
      crcs_pkg::OFS_CONTROL_1: nxt_rdata[7:0] = ctrl1_ff;
      crcs_pkg::OFS_DATA_HIGH: nxt_rdata[7:0] = data_high_ff;
      crcs_pkg::OFS_DATA_LOW: nxt_rdata[7:0] = data_low_ff;
      crcs_pkg::OFS_SCAN_CTRL: begin
        nxt_rdata[7:0] = {scan_ctrl_ff[7], scan_go_ff, scan_access_ff,
                          3'h0, scan_ctrl_ff[1:0]};
      end
      crcs_pkg::OFS_ACCUM: nxt_rdata[15:0] = accum_ff;
      crcs_pkg::OFS_POLY: nxt_rdata[15:0] = poly_ff;
      default: nxt_rdata = 32'h00000000;
    endcase
  end
  // Read data registered in setup so it is valid in access phase
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= nxt_rdata;
    end
  end

  logic unused_rd;
  assign unused_rd = rd_en;

endmodule : crcs_engine

// File: testbench/crcs_properties.sv
// Checker: port-level properties of the CRC engine
`timescale 1ns/1ps
module crcs_properties (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic debug_halt,
  input wire logic cpu_dead_cycle,
  input wire logic scan_trigger,
  input wire logic scan_end,
  input wire logic mem_read,
  input wire logic cpu_stall,
  input wire logic [15:0] mem_data
);
  logic [7:0] ctl0_ff; // Shadow of control 0
  logic [7:0] ctl1_ff; // Shadow of control 1
  logic [1:0] mode_ff; // Shadow of scanner mode
  ////////////////////////////////////////////////////////////
  // Shadows follow software writes at the access edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl0_ff <= 8'h00;
      ctl1_ff <= 8'h00;
      mode_ff <= 2'h0;
    end else if (psel && penable && pwrite) begin
      if (paddr == crcs_pkg::OFS_CONTROL_0) ctl0_ff <= pwdata[7:0];
      if (paddr == crcs_pkg::OFS_CONTROL_1) ctl1_ff <= pwdata[7:0];
      if (paddr == crcs_pkg::OFS_SCAN_CTRL) mode_ff <= pwdata[1:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire logic peek = mode_ff == crcs_pkg::MODE_PEEK; // Dead-cycle mode
  // Read setup of control 1
  sequence s_rd1;
    psel && !penable && !pwrite && paddr == crcs_pkg::OFS_CONTROL_1;
  endsequence
  // Halt seen on two edges, so any in-flight issue is behind us
  sequence s_halted;
    debug_halt [*2];
  endsequence
  a_halt_freeze: assert property (s_halted |-> !mem_read)
    else $error("fetch issued while halted");
  a_fetch_stall: assert property (mem_read && !peek |-> cpu_stall)
    else $error("fetch without core stall");
  a_peek_free: assert property (peek |-> !cpu_stall)
    else $error("core stalled in peek mode");
  a_peek_slot: assert property (mem_read && peek |-> cpu_dead_cycle)
    else $error("peek fetch outside dead cycle");
  a_fetch_ready: assert property (mem_read |-> ctl0_ff[6])
    else $error("fetch while shifter stopped");
  a_fetch_enabled: assert property (mem_read |-> ctl0_ff[7])
    else $error("fetch while engine disabled");
  a_word_len: assert property (s_rd1 |=> prdata[7:4] == ctl1_ff[7:4])
    else $error("word length readback");
  a_poly_len: assert property (s_rd1 |=> prdata[3:0] == ctl1_ff[3:0])
    else $error("poly length readback");
endmodule : crcs_properties

// File: testbench/crcs_memory_model.sv
// Partner: program memory answering scanner fetches
`timescale 1ns/1ps
module crcs_memory_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic mem_read,
  output logic [15:0] mem_data
);
  logic [15:0] addr_ff; // Next word address
  // Word comes the cycle after a fetch; otherwise the bus toggles,
  // so stale data never looks valid
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_ff <= 16'h0000;
      mem_data <= 16'hFFFF;
    end else if (mem_read) begin
      addr_ff <= addr_ff + 16'h0001;
      mem_data <= 16'hA5C3 ^ addr_ff;
    end else begin
      mem_data <= ~mem_data;
    end
  end
endmodule : crcs_memory_model

// File: testbench/crc_engine_with_scan_debug_hooks_tb.sv
// Testbench: register, shifter and scanner scenarios
`timescale 1ns/1ps
module crc_engine_with_scan_debug_hooks_tb;
  localparam logic [7:0] ofs_c0 = crcs_pkg::OFS_CONTROL_0;
  localparam logic [7:0] ofs_c1 = crcs_pkg::OFS_CONTROL_1;
  localparam logic [7:0] ofs_sc = crcs_pkg::OFS_SCAN_CTRL;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic debug_halt = 1'b0;
  logic cpu_dead_cycle = 1'b0;
  logic scan_trigger = 1'b0;
  logic scan_end = 1'b0;
  logic [31:0] prdata, q;
  logic pready, pslverr, mem_read, cpu_stall;
  logic [15:0] mem_data;
  int failures = 0, samples_checked = 0, cycles = 0, fetches = 0, n;
  crcs_engine dut_u (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .debug_halt(debug_halt), .cpu_dead_cycle(cpu_dead_cycle),
    .scan_trigger(scan_trigger), .scan_end(scan_end),
    .mem_read(mem_read), .cpu_stall(cpu_stall), .mem_data(mem_data));
  crcs_memory_model mem_u (.clk(clk), .reset_n(reset_n),
    .mem_read(mem_read), .mem_data(mem_data));
  ////////////////////////////////////////////////////////////
  initial forever #5 clk = ~clk;
  // Fetch count; non-blocking so the sequence reads a settled value
  always @(posedge clk) if (mem_read === 1'b1) fetches <= fetches + 1;
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      wrap_up();
    end
  end
  task wrap_up;
    if (failures == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h, want %h", $time, seen, exp);
    end
  endtask : chk
  // One APB transfer; idle cycle after it keeps drives one per step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rdc
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 8; i++) rdc(8'(4 * i), 32'h0);
    apb(1'b1, ofs_c1, 32'hA5);
    rdc(ofs_c1, 32'hA5);
    apb(1'b1, ofs_c0, 32'hFF);
    rdc(ofs_c0, 32'hD2);
    apb(1'b1, ofs_c0, 32'h80);
    apb(1'b1, crcs_pkg::OFS_DATA_HIGH, 32'h12);
    rdc(ofs_c0, 32'h80);
    apb(1'b1, crcs_pkg::OFS_DATA_LOW, 32'h34);
    rdc(ofs_c0, 32'hA1);
    apb(1'b1, ofs_c0, 32'hC0);
    repeat (16) @(posedge clk);
    rdc(ofs_c0, 32'hC0);
    apb(1'b1, ofs_c0, 32'h80);
    apb(1'b1, crcs_pkg::OFS_DATA_LOW, 32'h56);
    apb(1'b1, ofs_c0, 32'h00);
    rdc(ofs_c0, 32'h00);
    rdc(crcs_pkg::OFS_DATA_HIGH, 32'h12);
    apb(1'b1, ofs_c0, 32'hC0);
    // Every scanner mode fetches, then stops on the end condition
    for (int m = 0; m < 4; m++) begin
      cpu_dead_cycle <= (2'(m) == crcs_pkg::MODE_PEEK);
      scan_trigger <= 1'b0;
      apb(1'b1, ofs_sc, 32'hC0 | 32'(m));
      n = fetches;
      scan_trigger <= 1'b1;
      repeat (30) @(posedge clk);
      chk(32'(fetches > n), 32'h1);
      scan_end <= 1'b1;
      @(posedge clk);
      scan_end <= 1'b0;
      apb(1'b0, ofs_sc, 32'h0);
      chk(32'(q[6]), 32'h0);
    end
    // Burst started under halt, then halted and resumed mid-run
    n = fetches;
    debug_halt <= 1'b1;
    apb(1'b1, ofs_sc, 32'hC1);
    repeat (20) @(posedge clk);
    chk(32'(fetches - n), 32'h0);
    debug_halt <= 1'b0;
    repeat (20) @(negedge clk);
    chk(32'(fetches > n), 32'h1);
    chk({31'h0, cpu_stall}, 32'h1);
    @(posedge clk);
    debug_halt <= 1'b1;
    repeat (3) @(posedge clk);
    n = fetches;
    repeat (20) @(posedge clk);
    chk(32'(fetches - n), 32'h0);
    debug_halt <= 1'b0;
    repeat (20) @(posedge clk);
    chk(32'(fetches > n), 32'h1);
    scan_end <= 1'b1;
    @(posedge clk);
    scan_end <= 1'b0;
    repeat (2) @(negedge clk);
    chk({31'h0, cpu_stall}, 32'h0);
    // Peek waits for a dead cycle of the core before it fetches
    cpu_dead_cycle <= 1'b0;
    apb(1'b1, ofs_sc, 32'hC2);
    n = fetches;
    repeat (20) @(posedge clk);
    chk(32'(fetches - n), 32'h0);
    cpu_dead_cycle <= 1'b1;
    repeat (20) @(posedge clk);
    chk(32'(fetches > n), 32'h1);
    wrap_up();
  end
endmodule : crc_engine_with_scan_debug_hooks_tb
bind crcs_engine crcs_properties props_u (.clk(clk), .reset_n(reset_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .debug_halt(debug_halt), .cpu_dead_cycle(cpu_dead_cycle),
  .scan_trigger(scan_trigger), .scan_end(scan_end),
  .mem_read(mem_read), .cpu_stall(cpu_stall), .mem_data(mem_data));
